// ---- pkg/sweep_ctrl_pkg.sv ----
/*
  constants shared by the sweep storage and trigger control block.
  assumes a 40 mhz system clock and a classic wishbone register bus.
*/
package sweep_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and time
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ         = 40000;
  localparam int unsigned BASE_TIME_NS    = 500;
  localparam int unsigned BASE_CYCLES     = (BASE_TIME_NS * CLK_KHZ) / 1000000;
  localparam int unsigned AUTO_TIME_MS    = 22;
  localparam int unsigned AUTO_CYCLES     = AUTO_TIME_MS * CLK_KHZ;
  localparam int unsigned DEBOUNCE_CYCLES = 2000;
  localparam int unsigned MAX_CODE        = 26;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] CMD_ADDR    = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;
  localparam logic [3:0] POINT_ADDR  = 4'hc;

  // control fields
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned SRC_LSB    = 2;
  localparam int unsigned RISE_BIT   = 4;
  localparam int unsigned KEEP_BIT   = 5;
  localparam int unsigned ENA_BIT    = 6;
  localparam int unsigned ENB_BIT    = 7;
  localparam int unsigned CODE_LSB   = 8;
  localparam logic [12:0] CTRL_RESET = 13'h0150;

  // command bits, write one to act
  localparam int unsigned CMD_ARM    = 0;
  localparam int unsigned CMD_NEXT   = 1;
  localparam int unsigned CMD_LAST   = 2;
  localparam int unsigned CMD_MANUAL = 3;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_NORMAL, MODE_AUTO, MODE_CURSOR, MODE_SPARE} trig_mode_t;
  typedef enum logic [1:0] {SRC_EXT, SRC_CHAN_A, SRC_CHAN_B, SRC_SPARE} trig_src_t;
  typedef enum {ST_HALTED, ST_WAIT_TRIG, ST_SWEEP} acq_state_t;

endpackage

// ---- rtl/cmd_input_filter.sv ----
/*
  synchronises and debounces active-low command contacts, giving one pulse per press.
  assumes inputs come straight from pins or buttons, outside the clock domain.
*/
`timescale 1ns/100ps

module cmd_input_filter
  import sweep_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH  = 4,
  parameter int unsigned STABLE = sweep_ctrl_pkg::DEBOUNCE_CYCLES
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // contacts, low means pressed
  input  wire logic [WIDTH-1:0] press_n_i,
  // one-cycle pulse per press
  output logic      [WIDTH-1:0] press_o
);

  // ----------------------------------------------------------------
  // per-input filter
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic        meta_q;
      logic        sync_q;
      logic        level_q;
      logic [15:0] cnt_q;

      always_ff @(posedge clk_i)
      begin
        meta_q <= ~press_n_i[g];
        sync_q <= meta_q;
      end

      // accept a new level only after it has stood stable (see R20)
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          level_q    <= 1'b0;
          cnt_q      <= 16'h0000;
          press_o[g] <= 1'b0;
        end
        else
        begin
          press_o[g] <= 1'b0;
          if (sync_q == level_q)
            cnt_q <= 16'h0000;
          else if (cnt_q == 16'(STABLE - 1))
          begin
            level_q    <= sync_q;
            cnt_q      <= 16'h0000;
            press_o[g] <= sync_q;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  endgenerate

endmodule

// ---- rtl/sweep_storage_trigger_control.sv ----
/*
  sweep storage and trigger control: arms, captures and stops sweeps,
  qualifies triggers and paces sample points, with a wishbone register file.
  assumes trigger comparators and contacts arrive asynchronously on pins,
  and that sample memory accepts one write per enabled channel per strobe.
*/
`timescale 1ns/100ps

// What this block does
// R1: arm enters live; each valid trigger starts a sweep overwriting the old record
// R2: capture-next while waiting accepts one more trigger, then refuses triggers; during a sweep, that sweep is the last
// R3: capture-last stops triggers at once; a running sweep still finishes
// R4: with keep mode on, only every other location is written
// R5: in cursor mode a keep-mode change waits for the sweep end
// R6: each arm loads the keep-mode switch into the control state
// R7: in other modes a keep-mode change applies at the next sweep start
// R8: sample interval is 500 ns or 1 us times 1-2-5 steps up to 200 s
// R9: threshold crossings start sweeps only while live
// R10: rising setting triggers upward; otherwise downward transitions
// R11: after a trigger, re-arm needs an opposite recrossing past the margin
// R12: trigger source is external, channel a or channel b
// R13: a channel disabled for display still supplies triggers
// R14: a manual push-button trigger starts a sweep
// R15: remote inputs do the same as arm, capture-next, capture-last buttons
// R16: remote controller leaves inputs open for no action, grounds to act
// R17: operator keeps at least one channel enabled
// R18: both channels enabled acquire both; one enabled acts single-channel
// R19: auto mode starts a sweep if no trigger within 22 ms of sweep end
// R20: command inputs are synchronised, debounced and act once per press
// R21: capture-last beats capture-next, which beats arm, in one cycle
module sweep_storage_trigger_control
  import sweep_ctrl_pkg::*;
#(
  parameter int unsigned SWEEP_POINTS = 4096,
  parameter int unsigned ADDR_W       = 12,
  parameter int unsigned AUTO_WAIT    = sweep_ctrl_pkg::AUTO_CYCLES
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // panel buttons, low when pressed: arm, next, last, manual trigger
  input  wire logic [3:0]        panel_n_i,
  // remote contacts, grounded to act: arm, next, last
  input  wire logic [2:0]        remote_n_i,
  // comparators per source (ext, a, b): above threshold, below margin, above margin
  input  wire logic [2:0]        trig_above_i,
  input  wire logic [2:0]        trig_rearm_low_i,
  input  wire logic [2:0]        trig_rearm_high_i,
  // sample memory side
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_we_a_o,
  output logic                   mem_we_b_o,
  output logic                   dual_channel_o,
  // indicators
  output logic                   live_o,
  output logic                   triggered_o
);

  // ----------------------------------------------------------------
  // command inputs
  // ----------------------------------------------------------------
  logic [3:0]  panel_pulse;
  logic [2:0]  remote_pulse;
  logic [3:0]  sw_cmd_q;

  cmd_input_filter #(.WIDTH(4), .STABLE(DEBOUNCE_CYCLES)) u_panel_filter
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .press_n_i (panel_n_i),
    .press_o   (panel_pulse)
  );

  cmd_input_filter #(.WIDTH(3), .STABLE(DEBOUNCE_CYCLES)) u_remote_filter
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .press_n_i (remote_n_i),
    .press_o   (remote_pulse)
  );

  logic cmd_arm;
  logic cmd_next;
  logic cmd_last;
  logic cmd_manual;

  // remote contacts merge with the panel buttons (see R15)
  assign cmd_last   = panel_pulse[CMD_LAST] | remote_pulse[CMD_LAST] | sw_cmd_q[CMD_LAST];
  assign cmd_next   = panel_pulse[CMD_NEXT] | remote_pulse[CMD_NEXT] | sw_cmd_q[CMD_NEXT];
  assign cmd_arm    = panel_pulse[CMD_ARM] | remote_pulse[CMD_ARM] | sw_cmd_q[CMD_ARM];
  assign cmd_manual = panel_pulse[CMD_MANUAL] | sw_cmd_q[CMD_MANUAL];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [12:0] ctrl_q;
  trig_mode_t  mode;
  trig_src_t   src;
  logic        rise_sel;
  logic        keep_sw;
  logic        ena;
  logic        enb;
  logic [4:0]  code;

  assign mode     = trig_mode_t'(ctrl_q[MODE_LSB +: 2]);
  assign src      = trig_src_t'(ctrl_q[SRC_LSB +: 2]);
  assign rise_sel = ctrl_q[RISE_BIT];
  assign keep_sw  = ctrl_q[KEEP_BIT];
  assign ena      = ctrl_q[ENA_BIT];
  assign enb      = ctrl_q[ENB_BIT];
  assign code     = ctrl_q[CODE_LSB +: 5];

  // ----------------------------------------------------------------
  // trigger comparators
  // ----------------------------------------------------------------
  logic [8:0] cmp_meta_q;
  logic [8:0] cmp_sync_q;
  logic [8:0] cmp_raw;

  assign cmp_raw = {trig_rearm_high_i, trig_rearm_low_i, trig_above_i};

  genvar g;
  generate
    for (g = 0; g < 9; g++)
    begin : g_cmp
      always_ff @(posedge clk_i)
      begin
        cmp_meta_q[g] <= cmp_raw[g];
        cmp_sync_q[g] <= cmp_meta_q[g];
      end
    end
  endgenerate

  logic [1:0] src_idx;
  logic       above;
  logic       rearm_low;
  logic       rearm_high;
  logic       above_prev_q;
  logic       primed_q;
  logic       crossing;

  // the selected source triggers, whatever its display enable (see R12) (see R13)
  assign src_idx    = (src == SRC_SPARE) ? 2'd0 : src;
  assign above      = cmp_sync_q[src_idx];
  assign rearm_low  = cmp_sync_q[3 + src_idx];
  assign rearm_high = cmp_sync_q[6 + src_idx];

  // upward or downward crossing by slope setting (see R10)
  assign crossing = primed_q & (rise_sel ? (above & ~above_prev_q) : (~above & above_prev_q));

  // hysteresis: a crossing disarms until the opposite margin is passed (see R11)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      above_prev_q <= 1'b0;
      primed_q     <= 1'b0;
    end
    else
    begin
      above_prev_q <= above;
      if (crossing)
        primed_q <= 1'b0;
      else if (rise_sel ? rearm_low : rearm_high)
        primed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sample interval
  // ----------------------------------------------------------------
  function automatic logic [31:0] half_us_per_point(input logic [4:0] c);
    logic [31:0] v;
    int unsigned n;
    v = 32'h0000_0002;
    n = 0;
    if (c == 5'h00)
      v = 32'h0000_0001;
    else
    begin
      n = 32'(c) - 1;
      if (n % 3 == 1)
        v = 32'h0000_0004;
      else if (n % 3 == 2)
        v = 32'h0000_000a;
      for (int i = 0; i < 9; i++)
        if (i < n / 3)
          v = 32'(v * 32'd10);
    end
    return v;
  endfunction

  acq_state_t  state_q;
  logic [5:0]  base_cnt_q;
  logic [31:0] point_cnt_q;
  logic        sample_tick;

  // 500 ns base tick, then a per-point count of base ticks (see R8)
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ST_SWEEP)
    begin
      base_cnt_q  <= 6'h00;
      point_cnt_q <= 32'h0000_0000;
    end
    else if (base_cnt_q == 6'(BASE_CYCLES - 1))
    begin
      base_cnt_q <= 6'h00;
      if (point_cnt_q >= half_us_per_point(code) - 32'h0000_0001)
        point_cnt_q <= 32'h0000_0000;
      else
        point_cnt_q <= point_cnt_q + 32'h0000_0001;
    end
    else
      base_cnt_q <= base_cnt_q + 6'h01;
  end

  assign sample_tick = (state_q == ST_SWEEP) && (base_cnt_q == 6'(BASE_CYCLES - 1)) &&
                       (point_cnt_q >= half_us_per_point(code) - 32'h0000_0001);

  // ----------------------------------------------------------------
  // acquisition control
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic              one_more_q;
  logic              stopping_q;
  logic              keep_eff_q;
  logic [19:0]       auto_cnt_q;
  logic              auto_fire;
  logic              trig_ok;
  logic              sweep_end;

  assign auto_fire = (mode == MODE_AUTO) && (auto_cnt_q == 20'(AUTO_WAIT - 1));
  // triggers count only while waiting live (see R9) (see R14)
  assign trig_ok   = (state_q == ST_WAIT_TRIG) && !cmd_last && (crossing || cmd_manual || auto_fire);
  assign sweep_end = sample_tick && (addr_q == ADDR_W'(SWEEP_POINTS - 1));

  // auto trigger wait counter, restarted on entering the wait (see R19)
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != ST_WAIT_TRIG)
      auto_cnt_q <= 20'h00000;
    else if (auto_cnt_q != 20'(AUTO_WAIT - 1))
      auto_cnt_q <= auto_cnt_q + 20'h00001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= ST_HALTED;
      one_more_q <= 1'b0;
      stopping_q <= 1'b0;
    end
    else if (cmd_last)
    begin
      // capture-last wins over every other command (see R21) (see R3)
      stopping_q <= 1'b1;
      one_more_q <= 1'b0;
      if (state_q == ST_WAIT_TRIG)
        state_q <= ST_HALTED;
    end
    else
    begin
      if (cmd_next && state_q != ST_HALTED)
        one_more_q <= 1'b1;
      else if (cmd_arm)
      begin
        one_more_q <= 1'b0;
        stopping_q <= 1'b0;
      end
      case (state_q)
        ST_HALTED:
          if (cmd_arm && !cmd_next)
            state_q <= ST_WAIT_TRIG;
        ST_WAIT_TRIG:
          if (trig_ok)
            state_q <= ST_SWEEP;
        ST_SWEEP:
          if (sweep_end)
          begin
            // after capture-next the running sweep, or the next one if waiting, is the last, then halt (see R2)
            if (one_more_q || stopping_q)
            begin
              state_q    <= ST_HALTED;
              one_more_q <= 1'b0;
              stopping_q <= 1'b0;
            end
            else
              state_q <= ST_WAIT_TRIG;
          end
        default:
          state_q <= ST_HALTED;
      endcase
    end
  end

  // keep mode: arm loads it, cursor mode at sweep end, others at sweep start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      keep_eff_q <= 1'b0;
    else if (cmd_arm && !cmd_next && !cmd_last)
      keep_eff_q <= keep_sw;                                       // see R6
    else if (mode == MODE_CURSOR && sweep_end)
      keep_eff_q <= keep_sw;                                       // see R5
    else if (mode != MODE_CURSOR && trig_ok)
      keep_eff_q <= keep_sw;                                       // see R7
  end

  // point address and memory strobes; each sweep rewrites from zero (see R1)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q      <= '0;
      mem_addr_o  <= '0;
      mem_we_a_o  <= 1'b0;
      mem_we_b_o  <= 1'b0;
      triggered_o <= 1'b0;
    end
    else
    begin
      mem_we_a_o <= 1'b0;
      mem_we_b_o <= 1'b0;
      if (trig_ok)
      begin
        addr_q      <= '0;
        triggered_o <= 1'b1;
      end
      else if (sample_tick)
      begin
        addr_q     <= addr_q + 1'b1;
        mem_addr_o <= addr_q;
        // odd locations hold the protected record in keep mode (see R4)
        if (!(keep_eff_q && addr_q[0]))
        begin
          mem_we_a_o <= ena;                                       // see R18
          mem_we_b_o <= enb;                                       // see R18
        end
      end
      if (state_q != ST_SWEEP || sweep_end)
        triggered_o <= trig_ok;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      live_o         <= 1'b0;
      dual_channel_o <= 1'b0;
    end
    else
    begin
      live_o         <= (state_q != ST_HALTED);
      dual_channel_o <= ena & enb;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic wr;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (wr && wb_adr_i == CTRL_ADDR)
    begin
      if (wb_sel_i[0])
        ctrl_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        ctrl_q[12:8] <= (wb_dat_i[12:8] > 5'(MAX_CODE)) ? 5'(MAX_CODE) : wb_dat_i[12:8];
    end
  end

  // software commands act as one-cycle pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sw_cmd_q <= 4'h0;
    else if (wr && wb_adr_i == CMD_ADDR && wb_sel_i[0])
      sw_cmd_q <= wb_dat_i[3:0];
    else
      sw_cmd_q <= 4'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i)
        case (wb_adr_i)
          CTRL_ADDR:
            wb_dat_o <= {19'h00000, ctrl_q};
          STATUS_ADDR:
            wb_dat_o <= {26'h0000000, keep_eff_q, stopping_q, one_more_q,
                         triggered_o, state_q == ST_SWEEP, state_q != ST_HALTED};
          POINT_ADDR:
            wb_dat_o <= 32'(addr_q);
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

endmodule

// ---- bench/sweep_ctrl_monitor.sv ----
/*
  concurrent checks on the ports of the sweep storage and trigger control block.
  assumes a single clock with synchronous active-high reset.
*/
`timescale 1ns/100ps

module sweep_ctrl_monitor
  import sweep_ctrl_pkg::*;
#(
  parameter int unsigned SWEEP_POINTS = 4096,
  parameter int unsigned ADDR_W       = 12,
  parameter int unsigned AUTO_WAIT    = sweep_ctrl_pkg::AUTO_CYCLES
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [31:0]       wb_dat_o,
  input  wire logic              wb_ack_o,
  // contacts and comparators
  input  wire logic [3:0]        panel_n_i,
  input  wire logic [2:0]        remote_n_i,
  input  wire logic [2:0]        trig_above_i,
  input  wire logic [2:0]        trig_rearm_low_i,
  input  wire logic [2:0]        trig_rearm_high_i,
  // memory side and indicators
  input  wire logic [ADDR_W-1:0] mem_addr_o,
  input  wire logic              mem_we_a_o,
  input  wire logic              mem_we_b_o,
  input  wire logic              dual_channel_o,
  input  wire logic              live_o,
  input  wire logic              triggered_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic cmd_wr;
  assign cmd_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == CMD_ADDR
                  && wb_sel_i[0];

  a_ack_single:   assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  a_ack_follows:  assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_has_req:  assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_idle_data:    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_code_clamp:   assert property ((wb_ack_o && !wb_we_i && wb_adr_i == CTRL_ADDR)
    |-> wb_dat_o[12:8] <= MAX_CODE) else $error("interval code above limit");
  a_arm_live:     assert property ((cmd_wr && wb_dat_i[2:0] == 3'h1)
    |-> ##[1:5] live_o) else $error("arm did not enter live");
  a_last_halts:   assert property ((cmd_wr && wb_dat_i[2] && !triggered_o)
    |-> ##[1:5] !live_o) else $error("stop while waiting did not halt");
  a_trig_live:    assert property ($rose(triggered_o) |-> live_o)
    else $error("trigger accepted while halted");
  a_write_live:   assert property ((mem_we_a_o || mem_we_b_o) |-> live_o)
    else $error("memory write while halted");
  a_dual_both:    assert property ((mem_we_a_o && mem_we_b_o) |-> dual_channel_o)
    else $error("both channels written while not dual");

  c_trigger:  cover property ($rose(triggered_o));
  c_b_only:   cover property (mem_we_b_o && !mem_we_a_o);
  c_halt:     cover property ($fell(live_o));
endmodule

bind sweep_storage_trigger_control sweep_ctrl_monitor #(
  .SWEEP_POINTS(SWEEP_POINTS), .ADDR_W(ADDR_W), .AUTO_WAIT(AUTO_WAIT)
) mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .panel_n_i(panel_n_i),
  .remote_n_i(remote_n_i), .trig_above_i(trig_above_i),
  .trig_rearm_low_i(trig_rearm_low_i), .trig_rearm_high_i(trig_rearm_high_i),
  .mem_addr_o(mem_addr_o), .mem_we_a_o(mem_we_a_o), .mem_we_b_o(mem_we_b_o),
  .dual_channel_o(dual_channel_o), .live_o(live_o), .triggered_o(triggered_o)
);

// ---- bench/contact_model.sv ----
/*
  panel buttons and remote contacts as open-collector switches with pull-ups.
  assumes the press hold outlasts the block's debounce span.
*/
`timescale 1ns/100ps

module contact_model #(
  parameter int HOLD = 2100
)
(
  // clock
  input  wire logic       clk_i,
  // contacts, released lines read high through the pull-up
  output logic      [3:0] panel_n_o,
  output logic      [2:0] remote_n_o
);
  initial
  begin
    panel_n_o  = 4'hf;
    remote_n_o = 3'h7;
  end

  task automatic press(input logic rem, input int idx);
    @(posedge clk_i);
    if (rem) remote_n_o[idx] <= 1'b0;
    else panel_n_o[idx] <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    panel_n_o  <= 4'hf;
    remote_n_o <= 3'h7;
    repeat (HOLD) @(posedge clk_i);
  endtask
endmodule

// ---- bench/tb_top.sv ----
/*
  self-checking bench: register, command, trigger and contact scenarios.
  assumes a short sweep (16 points) and a short auto wait (50 cycles).
*/
`timescale 1ns/100ps

module tb_top;
  import sweep_ctrl_pkg::*;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [3:0]  adr       = 4'h0;
  logic [3:0]  sel       = 4'hf;
  logic [31:0] wdat      = 32'h0;
  logic [2:0]  above     = 3'h0;
  logic [2:0]  r_low     = 3'h0;
  logic [2:0]  r_high    = 3'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  panel_n;
  logic [2:0]  remote_n;
  logic [3:0]  maddr;
  logic        we_a;
  logic        we_b;
  logic        dual;
  logic        live;
  logic        trig;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          na        = 0;
  int          nb        = 0;
  int          nodd      = 0;

  always #12.5 clk_i = ~clk_i;

  sweep_storage_trigger_control #(.SWEEP_POINTS(16), .ADDR_W(4), .AUTO_WAIT(50)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .panel_n_i(panel_n), .remote_n_i(remote_n), .trig_above_i(above),
    .trig_rearm_low_i(r_low), .trig_rearm_high_i(r_high), .mem_addr_o(maddr),
    .mem_we_a_o(we_a), .mem_we_b_o(we_b), .dual_channel_o(dual), .live_o(live),
    .triggered_o(trig));

  contact_model contacts (.clk_i(clk_i), .panel_n_o(panel_n), .remote_n_o(remote_n));

  always @(posedge clk_i)
  begin
    if (we_a) na++;
    if (we_b) nb++;
    if ((we_a || we_b) && maddr[0]) nodd++;
  end

  task automatic close_out;
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) n_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask

  task automatic cmd(input logic [3:0] b);
    wr(CMD_ADDR, {28'h0, b});
    repeat (4) @(posedge clk_i);
  endtask

  task automatic fire(input int s, input logic rise);
    above[s] <= ~rise;
    repeat (4) @(posedge clk_i);
    if (rise) r_low[s] <= 1'b1;
    else r_high[s] <= 1'b1;
    repeat (4) @(posedge clk_i);
    r_low[s]  <= 1'b0;
    r_high[s] <= 1'b0;
    repeat (4) @(posedge clk_i);
    above[s] <= rise;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic settle(input logic v, input int lim);
    int k;
    k = 0;
    while (trig !== v && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("triggered", v, trig);
  endtask

  task automatic sweep(input int s, input logic rise);
    na   = 0;
    nb   = 0;
    nodd = 0;
    fire(s, rise);
    settle(1'b1, 10);
    settle(1'b0, 2000);
    @(posedge clk_i);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_ADDR, 32'h150, "ctrl reset");
    rd(STATUS_ADDR, 32'h0, "status reset");
    rd(4'h2, 32'h0, "unmapped");
    wr(STATUS_ADDR, 32'hff);
    rd(STATUS_ADDR, 32'h0, "status write");
    wr(CTRL_ADDR, 32'h1f50);
    rd(CTRL_ADDR, 32'h1a50, "ctrl clamp");
    wr(CTRL_ADDR, 32'h0050);
    fire(0, 1'b1);
    chk("trig halted", 1'b0, trig);
    cmd(4'h1);
    chk("live arm", 1'b1, live);
    rd(STATUS_ADDR, 32'h1, "status live");
    sweep(0, 1'b1);
    chk("points a", 16, na);
    cmd(4'h2);
    sweep(0, 1'b1);
    repeat (4) @(posedge clk_i);
    chk("live next", 1'b0, live);
    fire(0, 1'b1);
    chk("trig after next", 1'b0, trig);
    wr(CTRL_ADDR, 32'h0084);
    cmd(4'h1);
    sweep(1, 1'b0);
    chk("points a off", 0, na);
    chk("points b", 16, nb);
    wr(CTRL_ADDR, 32'h00f0);
    cmd(4'h1);
    sweep(0, 1'b1);
    chk("keep a", 8, na);
    chk("keep odd", 0, nodd);
    chk("dual", 1'b1, dual);
    wr(CTRL_ADDR, 32'h00d0);
    sweep(0, 1'b1);
    chk("keep off", 16, na);
    wr(CTRL_ADDR, 32'h00f2);
    sweep(0, 1'b1);
    chk("cursor hold", 16, na);
    sweep(0, 1'b1);
    chk("cursor keep", 8, na);
    cmd(4'h8);
    settle(1'b1, 10);
    settle(1'b0, 2000);
    wr(CTRL_ADDR, 32'h0051);
    settle(1'b1, 200);
    settle(1'b0, 2000);
    cmd(4'h4);
    chk("live stop", 1'b0, live);
    wr(CTRL_ADDR, 32'h0050);
    cmd(4'h5);
    chk("live prio", 1'b0, live);
    cmd(4'h1);
    fire(0, 1'b1);
    cmd(4'h4);
    chk("live sweeping", 1'b1, live);
    settle(1'b0, 2000);
    repeat (4) @(posedge clk_i);
    chk("live end", 1'b0, live);
    contacts.press(1'b1, 0);
    chk("remote arm", 1'b1, live);
    contacts.press(1'b0, 2);
    chk("panel stop", 1'b0, live);
    close_out();
  end

  initial
  begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
endmodule
